// ### rtl/dsp_pkg.sv
// Constants and types shared by the dual converter serial register port
package dsp_pkg;
  localparam int ADDR_W = 4;
  localparam int REG_W = 12;
  localparam int GAIN_W = 7;
  localparam int RES_W = 14;
  localparam int FRAME_W = ADDR_W + REG_W;
  localparam int STREAM_W = 2 * RES_W;
  localparam int CNT_W = 6;
  localparam int GAIN_SHIFT = 12;
  // Edge counts seen before the named falling edge
  localparam logic [CNT_W-1:0] EDGE_REQ = 6'h01;
  localparam logic [CNT_W-1:0] EDGE_WR_DONE = 6'h10;
  localparam logic [CNT_W-1:0] EDGE_OUT_FIRST = 6'h12;
  localparam logic [CNT_W-1:0] EDGE_OUT_END = 6'h2e;
  localparam logic [CNT_W-1:0] EDGE_MAX = 6'h2f;
  // Frame and config word fields
  localparam int FR_ADDR_HI = 15;
  localparam int FR_ADDR_LO = 12;
  localparam int GAIN_DATA_HI = 11;
  localparam int GAIN_DATA_LO = 5;
  localparam int RB_HI = 11;
  localparam int RB_LO = 8;
  localparam int CAL_BIT = 7;
  localparam int PWR_HI = 6;
  localparam int PWR_LO = 4;
  localparam int GS_HI = 3;
  localparam int GS_LO = 0;
  localparam int OFF_SIGN = 11;
  localparam int OFF_MAG_HI = 10;
  localparam int RES_SIGN = 13;
  // Register select codes
  localparam logic [ADDR_W-1:0] SEL_RESULT = 4'h0;
  localparam logic [ADDR_W-1:0] SEL_CONFIG = 4'h1;
  localparam logic [ADDR_W-1:0] SEL_OFF_A = 4'h2;
  localparam logic [ADDR_W-1:0] SEL_OFF_B = 4'h3;
  localparam logic [ADDR_W-1:0] SEL_GAIN_A = 4'h4;
  localparam logic [ADDR_W-1:0] SEL_GAIN_B = 4'h5;
  // Reset values
  localparam logic [REG_W-1:0] CFG_RST = 12'h000;
  localparam logic [REG_W-1:0] OFF_RST = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_RST = 7'h00;
  // Power select codes
  localparam logic [2:0] PWR_ADC_ONLY = 3'h1;
  localparam logic [2:0] PWR_CD_ONLY = 3'h2;
  localparam logic [2:0] PWR_AB_ONLY = 3'h3;
  localparam logic [2:0] PWR_COMPS = 3'h4;
  localparam logic [2:0] PWR_ALL_ON = 3'h5;
  typedef enum logic {CAL_IDLE, CAL_RUN} dsp_cal_t;
endpackage

// ### rtl/dsp_xing_if.sv
// Crossing bundle between the link side and the core side
`timescale 1ns/1ps
`default_nettype none
interface dsp_xing_if;
  logic wr_tog;
  logic [dsp_pkg::FRAME_W-1:0] wr_word;
  logic req_tog;
  logic [dsp_pkg::STREAM_W-1:0] stream_a;
  logic [dsp_pkg::STREAM_W-1:0] stream_b;
  modport link (output wr_tog, output wr_word, output req_tog, input stream_a, input stream_b);
  modport core (input wr_tog, input wr_word, input req_tog, output stream_a, output stream_b);
endinterface
`default_nettype wire

// ### rtl/dsp_link.sv
// Link-side frame engine clocked on falling serial clock edges
`timescale 1ns/1ps
`default_nettype none
module dsp_link (
  // Link clock and frame
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_resetn,
  input wire logic i_serial_in_pin,
  // Core side
  dsp_xing_if.link x,
  // Serial outputs
  output logic o_serial_out_a,
  output logic o_serial_out_a_oe,
  output logic o_serial_out_b,
  output logic o_serial_out_b_oe
);
  logic frame_rst;
  logic [dsp_pkg::CNT_W-1:0] cnt_q;
  logic [dsp_pkg::FRAME_W-1:0] sh_in_q;
  logic [dsp_pkg::STREAM_W-1:0] sa_q;
  logic [dsp_pkg::STREAM_W-1:0] sb_q;
  logic oe_q;

  // Chip select high clears the frame at once
  assign frame_rst = i_cs_n | ~i_resetn;

  // A falling edge coincident with chip select falling is lost in reset
  always_ff @(negedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q <= '0;
    end else if (cnt_q != dsp_pkg::EDGE_MAX) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  always_ff @(negedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      sh_in_q <= '0;
    end else if (cnt_q < dsp_pkg::EDGE_WR_DONE) begin
      sh_in_q <= {sh_in_q[dsp_pkg::FRAME_W-2:0], i_serial_in_pin};
    end
  end

  // Toggles survive chip select so the core sees every event
  always_ff @(negedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      x.wr_tog <= 1'b0;
      x.wr_word <= '0;
      x.req_tog <= 1'b0;
    end else begin
      if (cnt_q == dsp_pkg::EDGE_REQ) begin
        x.req_tog <= ~x.req_tog;
      end
      if (cnt_q == dsp_pkg::EDGE_WR_DONE) begin
        x.wr_word <= sh_in_q;
        x.wr_tog <= ~x.wr_tog;
      end
    end
  end

  always_ff @(negedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      oe_q <= 1'b0;
      sa_q <= '0;
      sb_q <= '0;
    end else if (cnt_q == dsp_pkg::EDGE_OUT_FIRST) begin
      oe_q <= 1'b1;
      sa_q <= x.stream_a;
      sb_q <= x.stream_b;
    end else if (cnt_q == dsp_pkg::EDGE_OUT_END) begin
      oe_q <= 1'b0;
    end else if (oe_q) begin
      sa_q <= {sa_q[dsp_pkg::STREAM_W-2:0], 1'b0};
      sb_q <= {sb_q[dsp_pkg::STREAM_W-2:0], 1'b0};
    end
  end

  assign o_serial_out_a = sa_q[dsp_pkg::STREAM_W-1];
  assign o_serial_out_b = sb_q[dsp_pkg::STREAM_W-1];
  assign o_serial_out_a_oe = oe_q;
  assign o_serial_out_b_oe = oe_q;

  default clocking @(negedge i_sclk); endclocking
  default disable iff (frame_rst);

  AST_OE_QUIET: assert property (cnt_q < dsp_pkg::EDGE_OUT_FIRST |-> !oe_q)
    else $error("output enabled before the first output edge");
  AST_OE_ON: assert property (cnt_q == dsp_pkg::EDGE_OUT_FIRST |=> oe_q ##1 oe_q)
    else $error("outputs not enabled at the first output edge");
  AST_OE_END: assert property (cnt_q == dsp_pkg::EDGE_OUT_END |=> !oe_q)
    else $error("outputs still enabled after the last edge");
  AST_COMMIT: assert property (cnt_q == dsp_pkg::EDGE_WR_DONE |=> x.wr_word == $past(sh_in_q))
    else $error("write word not committed at the write edge");
endmodule
`default_nettype wire

// ### rtl/dsp_port.sv
// Serial register port of a dual simultaneous-sampling converter
// Contract
// - Config word: readback select 11:8, calibration 7, power 6:4, gain 3:0.
// - Calibration start measures offsets; offsets are then subtracted from every result.
// - Power select field chooses which comparators and converters are powered.
// - Gain select field sets the amplifier gain ahead of both converters.
// - Serial input is sampled on each falling clock edge while selected; the link shifts in only edges 1 to 16.
// - Write frame is four address then twelve data bits; seventeen clocks needed.
// - Config and offset registers are twelve bits; gain registers seven bits.
// - Address arrives most significant first and selects the register loaded.
// - Gain writes take the seven bits after the address; trailing five low.
// - Select codes: result, config, offset A, offset B, gain A, gain B.
// - Reset clears config, both offset and both gain registers.
// - Selected register leaves on output A from edge 19; B keeps its result.
// - Chip select falling starts conversion (here the link requests it at falling edge 2); outputs stay off until edge 19.
// - From edge 19 both outputs send fourteen result bits, most significant first.
// - Chip select rising turns both outputs off at once.
// - Held low longer, each output sends the other result, off at edge 47.
// - A falling clock edge coincident with chip select falling is ignored.
// - The eight control bits configure the next conversion.
// - Power select 101 powers all comparators and both converters.
// - Requested calibration starts at the next chip select falling edge; here it starts with the request at edge 2 of the next frame.
`timescale 1ns/1ps
`default_nettype none
module dsp_port (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Serial link
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_a,
  output logic o_serial_out_a_oe,
  output logic o_serial_out_b,
  output logic o_serial_out_b_oe,
  // Converter core
  input wire logic i_conv_valid,
  input wire logic [dsp_pkg::RES_W-1:0] i_conv_a,
  input wire logic [dsp_pkg::RES_W-1:0] i_conv_b,
  output logic o_conv_start,
  output logic o_cal_active,
  // Analog configuration
  output logic [dsp_pkg::GS_HI:dsp_pkg::GS_LO] o_gain_select,
  output logic o_comp_ab_on,
  output logic o_comp_cd_on,
  output logic o_adc_on
);
  localparam int RW = dsp_pkg::RES_W;

  dsp_xing_if x ();

  dsp_link u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_resetn(i_resetn),
    .i_serial_in_pin(i_serial_in_pin),
    .x(x),
    .o_serial_out_a(o_serial_out_a),
    .o_serial_out_a_oe(o_serial_out_a_oe),
    .o_serial_out_b(o_serial_out_b),
    .o_serial_out_b_oe(o_serial_out_b_oe)
  );

  // Power select decode to {comparators AB, comparators CD, converters}
  function automatic logic [2:0] dsp_pwr_decode(input logic [2:0] sel);
    logic [2:0] en;
    case (sel)
      dsp_pkg::PWR_ADC_ONLY: en = 3'h1;
      dsp_pkg::PWR_CD_ONLY: en = 3'h2;
      dsp_pkg::PWR_AB_ONLY: en = 3'h4;
      dsp_pkg::PWR_COMPS: en = 3'h6;
      dsp_pkg::PWR_ALL_ON: en = 3'h7;
      default: en = 3'h0;
    endcase
    return en;
  endfunction

  // Offset words are sign and magnitude
  function automatic logic [RW-1:0] dsp_off_ext(input logic [dsp_pkg::REG_W-1:0] off);
    logic [RW-1:0] mag;
    mag = {3'h0, off[dsp_pkg::OFF_MAG_HI:0]};
    return off[dsp_pkg::OFF_SIGN] ? (14'h0000 - mag) : mag;
  endfunction

  // Gain register scales by 1 +/- code/4096, sign in the top bit
  function automatic logic [RW-1:0] dsp_gain_fix(
    input logic [RW-1:0] res,
    input logic [dsp_pkg::GAIN_W-1:0] g
  );
    logic signed [RW+dsp_pkg::GAIN_W-1:0] prod;
    logic [RW-1:0] adj;
    prod = $signed(res) * $signed({1'b0, g[dsp_pkg::GAIN_W-2:0]});
    adj = RW'(prod >>> dsp_pkg::GAIN_SHIFT);
    return g[dsp_pkg::GAIN_W-1] ? (res - adj) : (res + adj);
  endfunction

  // Event crossings from the link clock
  logic [2:0] wr_sync_q;
  logic [2:0] req_sync_q;
  logic wr_evt;
  logic req_evt;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_sync_q <= 3'h0;
      req_sync_q <= 3'h0;
    end else begin
      wr_sync_q <= {wr_sync_q[1:0], x.wr_tog};
      req_sync_q <= {req_sync_q[1:0], x.req_tog};
    end
  end

  assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
  assign req_evt = req_sync_q[2] ^ req_sync_q[1];

  // Write word is held by the link until its next commit
  logic [dsp_pkg::ADDR_W-1:0] wr_addr;
  logic [dsp_pkg::REG_W-1:0] wr_data;
  assign wr_addr = x.wr_word[dsp_pkg::FR_ADDR_HI:dsp_pkg::FR_ADDR_LO];
  assign wr_data = x.wr_word[dsp_pkg::REG_W-1:0];

  // Register file
  logic [dsp_pkg::REG_W-1:0] cfg_q;
  logic [dsp_pkg::REG_W-1:0] off_a_q;
  logic [dsp_pkg::REG_W-1:0] off_b_q;
  logic [dsp_pkg::GAIN_W-1:0] gain_a_q;
  logic [dsp_pkg::GAIN_W-1:0] gain_b_q;
  dsp_pkg::dsp_cal_t cal_st_q;
  logic cal_store;

  assign cal_store = (cal_st_q == dsp_pkg::CAL_RUN) && i_conv_valid;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= dsp_pkg::CFG_RST;
    end else if (wr_evt && wr_addr == dsp_pkg::SEL_CONFIG) begin
      cfg_q <= wr_data;
    end
  end

  // Calibration store yields to a host write in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      off_a_q <= dsp_pkg::OFF_RST;
      off_b_q <= dsp_pkg::OFF_RST;
    end else begin
      if (cal_store) begin
        off_a_q <= {i_conv_a[dsp_pkg::RES_SIGN], i_conv_a[dsp_pkg::OFF_MAG_HI:0]};
        off_b_q <= {i_conv_b[dsp_pkg::RES_SIGN], i_conv_b[dsp_pkg::OFF_MAG_HI:0]};
      end
      if (wr_evt && wr_addr == dsp_pkg::SEL_OFF_A) begin
        off_a_q <= wr_data;
      end
      if (wr_evt && wr_addr == dsp_pkg::SEL_OFF_B) begin
        off_b_q <= wr_data;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gain_a_q <= dsp_pkg::GAIN_RST;
      gain_b_q <= dsp_pkg::GAIN_RST;
    end else if (wr_evt && wr_addr == dsp_pkg::SEL_GAIN_A) begin
      gain_a_q <= wr_data[dsp_pkg::GAIN_DATA_HI:dsp_pkg::GAIN_DATA_LO];
    end else if (wr_evt && wr_addr == dsp_pkg::SEL_GAIN_B) begin
      gain_b_q <= wr_data[dsp_pkg::GAIN_DATA_HI:dsp_pkg::GAIN_DATA_LO];
    end
  end

  // Calibration runs on the conversion of the next frame
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_st_q <= dsp_pkg::CAL_IDLE;
      o_cal_active <= 1'b0;
    end else begin
      case (cal_st_q)
        dsp_pkg::CAL_IDLE: begin
          if (req_evt && cfg_q[dsp_pkg::CAL_BIT]) begin
            cal_st_q <= dsp_pkg::CAL_RUN;
            o_cal_active <= 1'b1;
          end
        end
        dsp_pkg::CAL_RUN: begin
          if (i_conv_valid) begin
            cal_st_q <= dsp_pkg::CAL_IDLE;
            o_cal_active <= 1'b0;
          end
        end
        default: begin
          cal_st_q <= dsp_pkg::CAL_IDLE;
          o_cal_active <= 1'b0;
        end
      endcase
    end
  end

  // Each frame start asks the converter for one conversion
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= req_evt;
    end
  end

  // Corrected results
  logic [RW-1:0] res_a;
  logic [RW-1:0] res_b;
  logic [RW-1:0] rd_word;
  logic [dsp_pkg::ADDR_W-1:0] rb_sel;

  assign rb_sel = cfg_q[dsp_pkg::RB_HI:dsp_pkg::RB_LO];
  assign res_a = dsp_gain_fix(i_conv_a - dsp_off_ext(off_a_q), gain_a_q);
  assign res_b = dsp_gain_fix(i_conv_b - dsp_off_ext(off_b_q), gain_b_q);

  always_comb begin
    case (rb_sel)
      dsp_pkg::SEL_CONFIG: rd_word = {2'h0, cfg_q};
      dsp_pkg::SEL_OFF_A: rd_word = {2'h0, off_a_q};
      dsp_pkg::SEL_OFF_B: rd_word = {2'h0, off_b_q};
      dsp_pkg::SEL_GAIN_A: rd_word = {7'h00, gain_a_q};
      dsp_pkg::SEL_GAIN_B: rd_word = {7'h00, gain_b_q};
      default: rd_word = res_a;
    endcase
  end

  // Streams are rebuilt per conversion and held for the link to load
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      x.stream_a <= '0;
      x.stream_b <= '0;
    end else if (i_conv_valid) begin
      if (cal_st_q == dsp_pkg::CAL_RUN) begin
        x.stream_a <= {i_conv_a, i_conv_b};
        x.stream_b <= {i_conv_b, i_conv_a};
      end else begin
        x.stream_a <= {rd_word, res_b};
        x.stream_b <= {res_b, res_a};
      end
    end
  end

  // Analog configuration from the config word
  logic [2:0] pwr_en;
  assign pwr_en = dsp_pwr_decode(cfg_q[dsp_pkg::PWR_HI:dsp_pkg::PWR_LO]);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_gain_select <= '0;
      o_comp_ab_on <= 1'b0;
      o_comp_cd_on <= 1'b0;
      o_adc_on <= 1'b0;
    end else begin
      o_gain_select <= cfg_q[dsp_pkg::GS_HI:dsp_pkg::GS_LO];
      o_comp_ab_on <= pwr_en[2];
      o_comp_cd_on <= pwr_en[1];
      o_adc_on <= pwr_en[0];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  AST_RESET_CLEAR: assert property (disable iff (1'b0)
    $rose(i_resetn) |-> cfg_q == dsp_pkg::CFG_RST && off_a_q == dsp_pkg::OFF_RST
      && off_b_q == dsp_pkg::OFF_RST && gain_a_q == dsp_pkg::GAIN_RST
      && gain_b_q == dsp_pkg::GAIN_RST)
    else $error("registers not cleared by reset");

  AST_WR_CONFIG: assert property (wr_evt && wr_addr == dsp_pkg::SEL_CONFIG
    |=> cfg_q == $past(wr_data))
    else $error("config write lost");

  AST_WR_GAIN: assert property (wr_evt && wr_addr == dsp_pkg::SEL_GAIN_B
    |=> gain_b_q == $past(wr_data[dsp_pkg::GAIN_DATA_HI:dsp_pkg::GAIN_DATA_LO]))
    else $error("gain write took the wrong bits");

  AST_WR_GAIN_A: assert property (wr_evt && wr_addr == dsp_pkg::SEL_GAIN_A
    |=> gain_a_q == $past(wr_data[dsp_pkg::GAIN_DATA_HI:dsp_pkg::GAIN_DATA_LO]))
    else $error("gain A write took the wrong bits");

  AST_WR_OFFSET: assert property (wr_evt && wr_addr == dsp_pkg::SEL_OFF_A
    |=> off_a_q == $past(wr_data))
    else $error("offset write lost");

  AST_WR_OFFSET_B: assert property (wr_evt && wr_addr == dsp_pkg::SEL_OFF_B
    |=> off_b_q == $past(wr_data))
    else $error("offset B write lost");

  AST_NO_WRITE: assert property (!wr_evt |=> $stable(cfg_q) && $stable(gain_a_q))
    else $error("register changed without a write");

  AST_CONV_START: assert property (req_evt |=> o_conv_start)
    else $error("frame start did not request a conversion");

  AST_CAL_START: assert property (req_evt && cfg_q[dsp_pkg::CAL_BIT]
    && cal_st_q == dsp_pkg::CAL_IDLE |=> o_cal_active && o_conv_start)
    else $error("calibration did not start with the frame");

  AST_CAL_STORE: assert property (cal_store && !wr_evt
    |=> off_b_q == {$past(i_conv_b[dsp_pkg::RES_SIGN]), $past(i_conv_b[dsp_pkg::OFF_MAG_HI:0])}
      && !o_cal_active)
    else $error("calibration offset not stored");

  AST_CAL_RAW: assert property (i_conv_valid && cal_st_q == dsp_pkg::CAL_RUN
    |=> x.stream_a == {$past(i_conv_a), $past(i_conv_b)})
    else $error("calibration stream not raw");

  AST_READBACK: assert property (i_conv_valid && cal_st_q == dsp_pkg::CAL_IDLE
    && rb_sel == dsp_pkg::SEL_OFF_A |=> x.stream_a[dsp_pkg::STREAM_W-1:RW] == {2'h0, $past(off_a_q)}
      && x.stream_b[dsp_pkg::STREAM_W-1:RW] == $past(res_b))
    else $error("readback word wrong");

  AST_RB_GAIN_B: assert property (i_conv_valid && cal_st_q == dsp_pkg::CAL_IDLE
    && rb_sel == dsp_pkg::SEL_GAIN_B |=> x.stream_a[dsp_pkg::STREAM_W-1:RW] == {7'h00, $past(gain_b_q)})
    else $error("gain B readback word wrong");

  AST_RESULT: assert property (i_conv_valid && cal_st_q == dsp_pkg::CAL_IDLE
    && rb_sel == dsp_pkg::SEL_RESULT |=> x.stream_a == {$past(res_a), $past(res_b)})
    else $error("result stream wrong");

  AST_RESULT_B: assert property (i_conv_valid && cal_st_q == dsp_pkg::CAL_IDLE
    |=> x.stream_b == {$past(res_b), $past(res_a)})
    else $error("stream B wrong");

  AST_POWER: assert property (cfg_q[dsp_pkg::PWR_HI:dsp_pkg::PWR_LO] == dsp_pkg::PWR_ALL_ON
    |=> o_comp_ab_on && o_comp_cd_on && o_adc_on)
    else $error("full power code did not power everything");

  AST_PWR_ADC: assert property (cfg_q[dsp_pkg::PWR_HI:dsp_pkg::PWR_LO] == dsp_pkg::PWR_ADC_ONLY
    |=> !o_comp_ab_on && !o_comp_cd_on && o_adc_on)
    else $error("converter-only power code decoded wrong");

  AST_GAIN_SEL: assert property (##1 o_gain_select == $past(cfg_q[dsp_pkg::GS_HI:dsp_pkg::GS_LO]))
    else $error("gain select does not follow the config word");
endmodule
`default_nettype wire

// ### testbench/dsp_host_model.sv
// Host serial master model: link clock, chip select, serial data in and output capture
`timescale 1ns/1ps
`default_nettype none
module dsp_host_model (
  // Link drive
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  // Device serial outputs
  input wire logic i_out_a,
  input wire logic i_oe_a,
  input wire logic i_out_b,
  input wire logic i_oe_b
);
  // Link clock stands high between frames
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end

  // Frame of n falling edges; bits leave on edges 1..16, outputs are taken before edges 20..47
  task automatic frame(input logic [15:0] word, input int n, input bit coinc,
                       output logic [27:0] a, output logic [27:0] b, output int oe_bad);
    oe_bad = 0;
    a = 28'h0;
    b = 28'h0;
    // A coincident clock edge lands while chip select still holds the frame clear
    if (coinc) begin
      o_sclk = 1'b0;
      o_cs_n <= 1'b0;
    end else begin
      o_cs_n = 1'b0;
    end
    #7.5;
    o_sclk = 1'b1;
    for (int e = 1; e <= n; e++) begin
      o_din = (e <= 16) ? word[16-e] : 1'b0;
      #7.5;
      if (e >= 20 && e <= 47) begin
        // An undriven line reads as the inverse of its last value
        a[47-e] = i_oe_a ? i_out_a : ~i_out_a;
        b[47-e] = i_oe_b ? i_out_b : ~i_out_b;
      end
      if ((i_oe_a !== (e >= 20 && e <= 47)) || (i_oe_b !== i_oe_a)) oe_bad++;
      o_sclk = 1'b0;
      #7.5;
      o_sclk = 1'b1;
      // Pause after the request edge gives the core time to fetch a result
      if (e == 2) #300;
    end
    #7.5;
    if (n >= 47 && i_oe_a !== 1'b0) oe_bad++;
    o_cs_n = 1'b1;
    #1;
    if (i_oe_a !== 1'b0 || i_oe_b !== 1'b0) oe_bad++;
    #20;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking testbench of the dual converter serial register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, resetn, sclk, cs_n, din, out_a, oe_a, out_b, oe_b;
  logic conv_start, cal_active, cal_seen, ab_on, cd_on, adc_on;
  logic [3:0] gsel;
  logic [13:0] conv_a, conv_b, ra, rb;
  logic [27:0] got_a, got_b;
  logic [2:0] pwr_tab [8];
  int err_total, checks_done, cycles, oe_bad;

  initial clk = 1'b0;
  always #25 clk = ~clk;

  dsp_port i_dut (
    .i_clk(clk), .i_resetn(resetn), .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in_pin(din),
    .o_serial_out_a(out_a), .o_serial_out_a_oe(oe_a), .o_serial_out_b(out_b), .o_serial_out_b_oe(oe_b),
    .i_conv_valid(conv_start), .i_conv_a(conv_a), .i_conv_b(conv_b), .o_conv_start(conv_start),
    .o_cal_active(cal_active), .o_gain_select(gsel), .o_comp_ab_on(ab_on), .o_comp_cd_on(cd_on),
    .o_adc_on(adc_on)
  );

  dsp_host_model i_host (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
    .i_out_a(out_a), .i_oe_a(oe_a), .i_out_b(out_b), .i_oe_b(oe_b)
  );

  always @(posedge clk) begin
    if (cal_active === 1'b1) cal_seen <= 1'b1;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One frame, then time for the register load to land in the core
  task automatic send(input logic [3:0] adr, input logic [11:0] d, input int n, input bit c);
    @(negedge clk);
    i_host.frame({adr, d}, n, c, got_a, got_b, oe_bad);
    repeat (10) @(negedge clk);
    chk("output enable", 28'h0, 28'(oe_bad));
  endtask

  // Config write that also reads the stream of the same frame
  task automatic rd(input logic [11:0] cfg, input logic [13:0] first, input int n, input bit c);
    logic [27:0] m;
    m = (n >= 47) ? 28'hfffffff : 28'hfffc000;
    send(4'h1, cfg, n, c);
    chk("out_a", {first, rb} & m, got_a);
    chk("out_b", {rb, ra} & m, got_b);
  endtask

  initial begin
    pwr_tab = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h0, 3'h0};
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    cal_seen = 1'b0;
    resetn = 1'b0;
    conv_a = 14'h0030;
    conv_b = 14'h0021;
    ra = 14'h0030;
    rb = 14'h0021;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk("config outputs", 28'h0, {21'h0, gsel, ab_on, cd_on, adc_on});
    $display("test reset done");
    for (int p = 0; p < 8; p++) begin
      send(4'h1, {5'h00, 3'(p), 1'b1, 3'(p)}, 17, 1'b0);
      chk("power and gain", 28'({pwr_tab[p], 1'b1, 3'(p)}), {21'h0, ab_on, cd_on, adc_on, gsel});
    end
    $display("test config decode done");
    send(4'h4, 12'haa0, 17, 1'b0);
    send(4'h4, 12'h540, 16, 1'b0);
    send(4'h5, 12'h660, 17, 1'b0);
    rd(12'h450, 14'h0030, 47, 1'b0);
    rd(12'h550, 14'h0055, 47, 1'b1);
    rd(12'h150, 14'h0033, 47, 1'b0);
    rd(12'h050, 14'h0150, 33, 1'b0);
    $display("test readback done");
    send(4'h1, 12'h0d0, 17, 1'b0);
    chk("calibration early", 28'h0, 28'(cal_seen));
    conv_a = 14'h0005;
    conv_b = 14'h0003;
    ra = 14'h0005;
    rb = 14'h0003;
    rd(12'h050, 14'h0005, 47, 1'b0);
    chk("calibration ran", 28'h1, 28'(cal_seen));
    conv_a = 14'h0030;
    conv_b = 14'h0021;
    ra = 14'h002b;
    rb = 14'h001e;
    rd(12'h250, 14'h002b, 47, 1'b0);
    rd(12'h350, 14'h0005, 47, 1'b0);
    rd(12'h050, 14'h0003, 47, 1'b0);
    rd(12'h050, 14'h002b, 47, 1'b0);
    $display("test calibration done");
    send(4'h2, 12'h807, 17, 1'b0);
    send(4'h3, 12'h002, 17, 1'b0);
    ra = 14'h0037;
    rb = 14'h001f;
    rd(12'h250, 14'h0037, 47, 1'b0);
    rd(12'hf50, 14'h0807, 47, 1'b0);
    rd(12'h050, 14'h0037, 47, 1'b0);
    $display("test offset write done");
    stop_test();
  end
endmodule
`default_nettype wire
